// ===== core/btrw_engine.sv
// remote write block transfer engine: local read, request send, remote write, response count
`default_nettype none
// Contract
// - write request follows control bit 0
// - remote write becomes local DRAM read first
// - go-write and go-read strobes load command
// - arbitrate DRAM, request buffer, channel; reserve
// - DRAM driven by row, column, write strobes
// - read data held in request buffer
// - address sent only with buffer permission
// - bit 12 marks virtual, translate to logical
// - logical number indexes routing tag table
// - type 6 request with parity, tag, address
// - one block per packet, X router
// - buffer stores packet minus tag; backpressure
// - check target, kind, parity, destination
// - unload grant when buffer holds packet
// - write DRAM, form response from source
// - type 0 response, parity cmd and dest
// - response checks command parity and destination
// - response decrements counter; zero with no blocks left signals completion
module btrw_engine
  import btrw_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ctrl_go,
  input wire logic [CNT_W-1:0] xfer_blocks,
  input wire logic [ADDR_W-1:0] xfer_local_addr,
  input wire logic [ADDR_W-1:0] xfer_remote_addr,
  input wire logic [PE_W-1:0] xfer_dest_pe,
  input wire logic [LPE_W-1:0] node_pe_id,
  input wire logic [LPE_W-1:0] pe_virt_base,
  input wire logic tag_wr_en,
  input wire logic [TAG_IDX_W-1:0] tag_wr_addr,
  input wire logic [TAG_W-1:0] tag_wr_data,
  output logic write_reference_request,
  output logic go_write_cmd,
  output logic go_read_cmd,
  output logic dram_req,
  input wire logic dram_grant,
  output logic chan_req,
  input wire logic chan_grant,
  output logic dram_ras_n,
  output logic dram_cas_n,
  output logic dram_we_n,
  output logic [DADDR_W-1:0] dram_addr,
  output logic [DATA_W-1:0] dram_wdata,
  input wire logic [DATA_W-1:0] dram_rdata,
  output logic tx_valid,
  output logic [DATA_W-1:0] tx_phit,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [DATA_W-1:0] rx_phit,
  input wire logic rx_last,
  output logic rx_ready,
  output logic buffer_unload_grant,
  output logic parity_error,
  output logic dest_error,
  output logic [CNT_W-1:0] outstanding_count,
  output logic xfer_complete
);
  btrw_state_type state_q;
  logic [CNT_W-1:0] blocks_left_q;
  logic [ADDR_W-1:0] laddr_q;
  logic [ADDR_W-1:0] raddr_q;
  logic [PE_W-1:0] dest_q;
  logic kind_q;
  logic [2:0] wait_q;
  logic [ADDR_W-1:0] op_addr_q;
  logic [ADDR_W-1:0] pkt_raddr_q;
  logic [PE_W-1:0] pkt_dest_q;
  logic [DATA_W-1:0] data_q;
  logic [TAG_IDX_W-1:0] tag_idx_q;
  logic [TAG_W-1:0] tag_q;
  logic [DATA_W-1:0] tx_buf_q [3];
  logic [1:0] tx_idx_q;
  logic [1:0] tx_num_q;
  logic [DATA_W-1:0] rx_buf_q [3];
  logic [1:0] rx_idx_q;
  logic rx_full_q;

  // decode of the held inbound packet
  logic [DATA_W-1:0] rx_hdr;
  logic [CMD_W-1:0] rx_cmd;
  logic [PE_W-1:0] rx_dest;
  logic [PE_W-1:0] rx_src;
  logic [ADDR_W-1:0] rx_addr;
  logic cmd_par_ok;
  logic req_par_ok;
  logic dest_ok;
  logic req_ok;
  logic resp_ok;
  logic go_fire;
  logic tx_done;
  logic rx_take;
  logic start;

  assign rx_hdr = rx_buf_q[0];
  assign rx_cmd = rx_hdr[HDR_CMD_LSB +: CMD_W];
  assign rx_dest = rx_hdr[HDR_DEST_LSB +: PE_W];
  assign rx_src = rx_hdr[HDR_SRC_LSB +: PE_W];
  assign rx_addr = rx_buf_q[1][ADDR_W-1:0];
  // responses carry no source, so only the command parity is checked
  assign cmd_par_ok = rx_hdr[HDR_PCMD] == ^rx_cmd;
  assign req_par_ok = cmd_par_ok && rx_hdr[HDR_PSRC] == ^rx_src
      && rx_buf_q[1][ADDR_PAR_BIT] == ^rx_addr;
  assign dest_ok = rx_dest == {1'b0, node_pe_id};
  assign req_ok = rx_cmd == CMD_REQ_WRITE && req_par_ok && dest_ok;
  assign resp_ok = rx_cmd == CMD_RESP_WRITE && cmd_par_ok && dest_ok;
  assign go_fire = state_q == ST_IDLE && !rx_full_q && write_reference_request
      && blocks_left_q != CNT_ZERO;
  assign tx_done = tx_valid && tx_ready && tx_last;
  assign rx_take = rx_valid && rx_ready;
  assign start = ctrl_go && !write_reference_request && blocks_left_q == CNT_ZERO;

  btrw_tag_table u_tag (
    .mclk(mclk),
    .wr_en(tag_wr_en),
    .wr_addr(tag_wr_addr),
    .wr_data(tag_wr_data),
    .rd_addr(tag_idx_q),
    .rd_data_q(tag_q)
  );

  // control bit, transfer setup and per-block address stepping
  always_ff @(posedge mclk) begin
    if (reset) begin
      write_reference_request <= 1'b0;
      blocks_left_q <= CNT_ZERO;
      laddr_q <= '0;
      raddr_q <= '0;
      dest_q <= '0;
    end else begin
      write_reference_request <= ctrl_go;
      if (start) begin
        blocks_left_q <= xfer_blocks;
        laddr_q <= xfer_local_addr;
        raddr_q <= xfer_remote_addr;
        dest_q <= xfer_dest_pe;
      end else begin
        if (tx_done && !kind_q) begin
          blocks_left_q <= blocks_left_q - CNT_ONE;
        end
        if (go_fire) begin
          laddr_q <= laddr_q + 24'h000001;
          raddr_q <= raddr_q + 24'h000001;
        end
      end
    end
  end

  // sequencer: command load, arbitration, dram cycle, unload and checks
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      kind_q <= 1'b0;
      wait_q <= 3'h0;
      go_write_cmd <= 1'b0;
      go_read_cmd <= 1'b0;
      dram_req <= 1'b0;
      chan_req <= 1'b0;
      dram_ras_n <= 1'b1;
      dram_cas_n <= 1'b1;
      dram_we_n <= 1'b1;
      dram_addr <= '0;
      dram_wdata <= '0;
      op_addr_q <= '0;
      pkt_raddr_q <= '0;
      pkt_dest_q <= '0;
      data_q <= '0;
      tag_idx_q <= '0;
      buffer_unload_grant <= 1'b0;
      parity_error <= 1'b0;
      dest_error <= 1'b0;
    end else begin
      go_write_cmd <= 1'b0;
      go_read_cmd <= 1'b0;
      buffer_unload_grant <= 1'b0;
      parity_error <= 1'b0;
      dest_error <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          // inbound traffic first so the router is never starved
          if (rx_full_q) begin
            buffer_unload_grant <= 1'b1;
            state_q <= ST_UNLOAD;
          end else if (go_fire) begin
            go_write_cmd <= 1'b1;
            go_read_cmd <= 1'b1;
            kind_q <= 1'b0;
            op_addr_q <= laddr_q;
            pkt_raddr_q <= raddr_q;
            pkt_dest_q <= {1'b0, btrw_logical(dest_q, pe_virt_base)};
            tag_idx_q <= TAG_IDX_W'(btrw_logical(dest_q, pe_virt_base));
            state_q <= ST_ARB;
          end
        end
        ST_UNLOAD: begin
          if (req_ok) begin
            kind_q <= 1'b1;
            op_addr_q <= rx_addr;
            data_q <= rx_buf_q[2];
            pkt_dest_q <= rx_src;
            tag_idx_q <= rx_src[TAG_IDX_W-1:0];
            state_q <= ST_ARB;
          end else begin
            // bad packets are dropped; the pulses tell the error logic why
            parity_error <= rx_cmd == CMD_REQ_WRITE ? !req_par_ok : !cmd_par_ok;
            dest_error <= !dest_ok;
            state_q <= ST_IDLE;
          end
        end
        ST_ARB: begin
          dram_req <= 1'b1;
          chan_req <= 1'b1;
          // both must be held at once; chan stays reserved until sent
          if (dram_req && chan_req && dram_grant && chan_grant) begin
            dram_ras_n <= 1'b0;
            dram_addr <= op_addr_q[ADDR_W-1 -: DADDR_W];
            wait_q <= RCD_CNT;
            state_q <= ST_ROW;
          end
        end
        ST_ROW: begin
          if (wait_q == 3'h0) begin
            dram_cas_n <= 1'b0;
            dram_we_n <= !kind_q;
            dram_addr <= op_addr_q[DADDR_W-1:0];
            dram_wdata <= data_q;
            wait_q <= CAS_CNT;
            state_q <= ST_COL;
          end else begin
            wait_q <= wait_q - 3'h1;
          end
        end
        ST_COL: begin
          if (wait_q == 3'h0) begin
            if (!kind_q) begin
              data_q <= dram_rdata;
            end
            dram_ras_n <= 1'b1;
            dram_cas_n <= 1'b1;
            dram_we_n <= 1'b1;
            dram_req <= 1'b0;
            state_q <= ST_LOOK;
          end else begin
            wait_q <= wait_q - 3'h1;
          end
        end
        ST_LOOK: begin
          state_q <= ST_SEND;
        end
        ST_SEND: begin
          if (tx_done) begin
            chan_req <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // outgoing packet: tag phit, header, then address and data for requests
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_valid <= 1'b0;
      tx_phit <= '0;
      tx_last <= 1'b0;
      tx_idx_q <= 2'h0;
      tx_num_q <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        tx_buf_q[i] <= '0;
      end
    end else if (state_q == ST_LOOK) begin
      // the held read data and address leave only once the buffer is reserved
      tx_valid <= 1'b1;
      tx_phit <= {{(DATA_W - TAG_W){1'b0}}, tag_q};
      tx_last <= 1'b0;
      tx_idx_q <= 2'h0;
      if (!kind_q) begin
        tx_num_q <= REQ_LAST_IDX;
        tx_buf_q[0] <= btrw_header(CMD_REQ_WRITE, pkt_dest_q,
            {1'b0, node_pe_id}, 1'b1);
        tx_buf_q[1] <= {^pkt_raddr_q, {(DATA_W - ADDR_W - 1){1'b0}}, pkt_raddr_q};
        tx_buf_q[2] <= data_q;
      end else begin
        tx_num_q <= RESP_LAST_IDX;
        tx_buf_q[0] <= btrw_header(CMD_RESP_WRITE, pkt_dest_q, '0, 1'b0);
        tx_buf_q[1] <= '0;
        tx_buf_q[2] <= '0;
      end
    end else if (tx_valid && tx_ready) begin
      if (tx_last) begin
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
      end else begin
        tx_phit <= tx_buf_q[tx_idx_q];
        tx_idx_q <= tx_idx_q + 2'h1;
        tx_last <= tx_idx_q + 2'h1 == tx_num_q;
      end
    end
  end

  // inbound buffer: tag phit dropped, ready withdrawn while a packet waits
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_idx_q <= 2'h0;
      rx_full_q <= 1'b0;
      rx_ready <= 1'b1;
      for (int i = 0; i < 3; i++) begin
        rx_buf_q[i] <= '0;
      end
    end else if (state_q == ST_UNLOAD) begin
      rx_full_q <= 1'b0;
      rx_ready <= 1'b1;
    end else if (rx_take) begin
      if (rx_idx_q != 2'h0) begin
        rx_buf_q[rx_idx_q - 2'h1] <= rx_phit;
      end
      if (rx_last) begin
        rx_idx_q <= 2'h0;
        rx_full_q <= 1'b1;
        rx_ready <= 1'b0;
      end else begin
        rx_idx_q <= rx_idx_q + 2'h1;
      end
    end
  end

  // outstanding references; increment and decrement never share a cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      outstanding_count <= CNT_ZERO;
      xfer_complete <= 1'b0;
    end else begin
      xfer_complete <= 1'b0;
      if (tx_done && !kind_q) begin
        outstanding_count <= outstanding_count + CNT_ONE;
      end else if (state_q == ST_UNLOAD && resp_ok && outstanding_count != CNT_ZERO) begin
        outstanding_count <= outstanding_count - CNT_ONE;
        xfer_complete <= outstanding_count == CNT_ONE && blocks_left_q == CNT_ZERO;
      end
    end
  end

  a_req_tracks_bit: assert property (@(posedge mclk) disable iff (reset)
    $rose(ctrl_go) |=> write_reference_request)
    else $error("write reference request did not follow control bit");
  a_go_pair: assert property (@(posedge mclk) disable iff (reset)
    go_write_cmd == go_read_cmd)
    else $error("go strobes not paired");
  a_go_then_arb: assert property (@(posedge mclk) disable iff (reset)
    go_read_cmd |=> dram_req && chan_req)
    else $error("no dram arbitration after go strobes");
  a_ras_granted: assert property (@(posedge mclk) disable iff (reset)
    $fell(dram_ras_n) |-> $past(dram_grant) && $past(chan_grant) && chan_req)
    else $error("row strobe without both grants");
  a_cas_row_gap: assert property (@(posedge mclk) disable iff (reset)
    $fell(dram_ras_n) |-> dram_cas_n [*5] ##1 !dram_cas_n && !dram_ras_n)
    else $error("column strobe timing wrong");
  a_req_header: assert property (@(posedge mclk) disable iff (reset)
    tx_valid && tx_idx_q == 2'h1 && tx_num_q == REQ_LAST_IDX |->
      tx_phit[HDR_CMD_LSB +: CMD_W] == CMD_REQ_WRITE
      && tx_phit[HDR_PDEST] == ^tx_phit[HDR_DEST_LSB +: PE_W]
      && tx_phit[HDR_PSRC] == ^tx_phit[HDR_SRC_LSB +: PE_W])
    else $error("request header malformed");
  a_full_no_ready: assert property (@(posedge mclk) disable iff (reset)
    rx_full_q |-> !rx_ready)
    else $error("ready while buffer full");
  a_grant_full: assert property (@(posedge mclk) disable iff (reset)
    buffer_unload_grant |-> rx_full_q ##1 rx_ready)
    else $error("unload grant without held packet");
  a_count_up: assert property (@(posedge mclk) disable iff (reset)
    tx_done && !kind_q |=> outstanding_count == $past(outstanding_count) + CNT_ONE)
    else $error("request did not raise outstanding count");
  a_done_zero: assert property (@(posedge mclk) disable iff (reset)
    xfer_complete |-> outstanding_count == CNT_ZERO && $past(resp_ok))
    else $error("completion with references outstanding");

  c_request_sent: cover property (@(posedge mclk) disable iff (reset)
    tx_done && !kind_q);
  c_response_sent: cover property (@(posedge mclk) disable iff (reset)
    tx_done && kind_q);
  c_complete: cover property (@(posedge mclk) disable iff (reset)
    xfer_complete);
endmodule
`default_nettype wire

// ===== core/btrw_pkg.sv
// shared constants, types and helpers for the block transfer remote write engine
`default_nettype none
package btrw_pkg;
  // fixed widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 64;
  localparam int PE_W = 13;
  localparam int LPE_W = 12;
  localparam int TAG_W = 16;
  localparam int TAG_IDX_W = 8;
  localparam int CMD_W = 4;
  localparam int CNT_W = 17;
  localparam int DADDR_W = 12;
  // packet types
  localparam logic [CMD_W-1:0] CMD_REQ_WRITE = 4'h6;
  localparam logic [CMD_W-1:0] CMD_RESP_WRITE = 4'h0;
  // header phit field positions
  localparam int HDR_CMD_LSB = 60;
  localparam int HDR_DEST_LSB = 47;
  localparam int HDR_SRC_LSB = 34;
  localparam int HDR_PCMD = 2;
  localparam int HDR_PDEST = 1;
  localparam int HDR_PSRC = 0;
  localparam int ADDR_PAR_BIT = 63;
  localparam int PE_VIRT_BIT = 12;
  // phit counts per packet, minus one (the routing tag phit is index 0)
  localparam logic [1:0] REQ_LAST_IDX = 2'h3;
  localparam logic [1:0] RESP_LAST_IDX = 2'h1;
  // dram timing, least times rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_RCD_NS = 20;
  localparam int T_CAS_NS = 15;
  localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_CYC = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] RCD_CNT = 3'(RCD_CYC - 1);
  localparam logic [2:0] CAS_CNT = 3'(CAS_CYC - 1);
  // counter reset value and unit step
  localparam logic [CNT_W-1:0] CNT_ZERO = 17'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE = 17'h00001;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_UNLOAD = 4'h1,
    ST_ARB = 4'h2,
    ST_ROW = 4'h3,
    ST_COL = 4'h4,
    ST_LOOK = 4'h5,
    ST_SEND = 4'h6
  } btrw_state_type;

  // header phit with per-field parity; src parity only when asked
  function automatic logic [DATA_W-1:0] btrw_header(input logic [CMD_W-1:0] cmd,
      input logic [PE_W-1:0] dest, input logic [PE_W-1:0] src, input logic with_src);
    logic [DATA_W-1:0] h;
    h = '0;
    h[HDR_CMD_LSB +: CMD_W] = cmd;
    h[HDR_DEST_LSB +: PE_W] = dest;
    h[HDR_SRC_LSB +: PE_W] = with_src ? src : '0;
    h[HDR_PCMD] = ^cmd;
    h[HDR_PDEST] = ^dest;
    h[HDR_PSRC] = with_src ? ^src : 1'b0;
    return h;
  endfunction

  // virtual numbers are rebased into logical ones; logical pass through
  function automatic logic [LPE_W-1:0] btrw_logical(input logic [PE_W-1:0] pe,
      input logic [LPE_W-1:0] base);
    logic [LPE_W-1:0] l;
    l = pe[PE_VIRT_BIT] ? pe[LPE_W-1:0] + base : pe[LPE_W-1:0];
    return l;
  endfunction
endpackage
`default_nettype wire

// ===== core/btrw_tag_table.sv
// routing tag lookup memory with registered read data
`default_nettype none
module btrw_tag_table
  import btrw_pkg::*;
(
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [TAG_IDX_W-1:0] wr_addr,
  input wire logic [TAG_W-1:0] wr_data,
  input wire logic [TAG_IDX_W-1:0] rd_addr,
  output logic [TAG_W-1:0] rd_data_q
);
  logic [TAG_W-1:0] mem [2**TAG_IDX_W];

  // no reset on the array; software loads it before any transfer
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ===== tb/btrw_far_model.sv
// far side model: dram grants and read data, router stalls, remote node answers
`default_nettype none
module btrw_far_model
  import btrw_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic dram_req,
  output var logic dram_grant,
  input wire logic chan_req,
  output var logic chan_grant,
  input wire logic dram_cas_n,
  input wire logic dram_we_n,
  input wire logic [DADDR_W-1:0] dram_addr,
  output var logic [DATA_W-1:0] dram_rdata,
  input wire logic tx_valid,
  input wire logic [DATA_W-1:0] tx_phit,
  input wire logic tx_last,
  output var logic tx_ready,
  output var logic rx_valid,
  output var logic [DATA_W-1:0] rx_phit,
  output var logic rx_last,
  input wire logic rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] idx_q;
  logic [PE_W-1:0] src_q;
  logic [PE_W-1:0] resp_q [$];

  // header phit with per-field parity
  function automatic logic [DATA_W-1:0] hdr(input logic [3:0] c, input logic [12:0] d,
      input logic [12:0] s, input logic ws);
    hdr = '0;
    hdr[63:60] = c;
    hdr[59:47] = d;
    hdr[46:34] = ws ? s : 13'h0000;
    hdr[2] = ^c;
    hdr[1] = ^d;
    hdr[0] = ws ? ^s : 1'b0;
  endfunction

  // stored word is a pattern of the column, so the bench can predict it
  function automatic logic [DATA_W-1:0] dat(input logic [11:0] c);
    return {16'h5a5a, 36'h0, c};
  endfunction

  initial begin
    dram_grant = 1'b0;
    chan_grant = 1'b0;
    dram_rdata = '0;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_phit = '0;
    rx_last = 1'b0;
  end

  // slow and prompt grants; read data toggles whenever no read is addressed
  always @(negedge mclk) begin
    dram_grant <= dram_req && ($urandom_range(1) != 0);
    chan_grant <= chan_req && ($urandom_range(2) != 0);
    tx_ready <= $urandom_range(3) != 0;
    dram_rdata <= (!dram_cas_n && dram_we_n) ? dat(dram_addr) : ~dram_rdata;
  end

  // note the source of every four-phit request accepted from the x router
  always @(posedge mclk) begin
    if (reset) begin
      idx_q <= 2'h0;
    end else if (tx_valid && tx_ready) begin
      idx_q <= tx_last ? 2'h0 : idx_q + 2'h1;
      if (idx_q == 2'h1) src_q <= tx_phit[46:34];
      if (tx_last && idx_q == 2'h3) resp_q.push_back(src_q);
    end
  end

  // one packet into the engine, each phit held until taken
  task automatic send(input logic [63:0] p [4], input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      rx_valid <= 1'b1;
      rx_phit <= p[i];
      rx_last <= (i == n - 1);
      @(posedge mclk);
      while (!rx_ready) @(posedge mclk);
    end
    @(negedge mclk);
    rx_valid <= 1'b0;
    rx_phit <= ~rx_phit;
    rx_last <= 1'b0;
  endtask

  // remote node answers each write after a random pause
  initial begin : answer
    logic [PE_W-1:0] s;
    forever begin
      wait (resp_q.size() != 0);
      repeat ($urandom_range(6)) @(negedge mclk);
      s = resp_q.pop_front();
      send('{64'hfeed_0000_0000_0001, hdr(4'h0, s, 13'h0, 1'b0), '0, '0}, 2);
    end
  end
endmodule
`default_nettype wire

// ===== tb/btrw_engine_tb_top.sv
// self-checking bench for the remote write block transfer engine
`default_nettype none
module btrw_engine_tb_top
  import btrw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, reset = 1'b1, ctrl_go = 1'b0, tag_wr_en = 1'b0;
  logic [CNT_W-1:0] xfer_blocks = '0;
  logic [ADDR_W-1:0] xfer_local_addr = '0, xfer_remote_addr = '0;
  logic [PE_W-1:0] xfer_dest_pe = '0;
  logic [LPE_W-1:0] node_pe_id = '0, pe_virt_base = '0;
  logic [TAG_IDX_W-1:0] tag_wr_addr = '0;
  logic [TAG_W-1:0] tag_wr_data = '0;
  logic write_reference_request, go_write_cmd, go_read_cmd, dram_req, dram_grant, chan_req;
  logic chan_grant, dram_ras_n, dram_cas_n, dram_we_n, tx_valid, tx_last, tx_ready, rx_valid;
  logic rx_last, rx_ready, buffer_unload_grant, parity_error, dest_error, xfer_complete, done;
  logic [DADDR_W-1:0] dram_addr;
  logic [DATA_W-1:0] dram_wdata, dram_rdata, tx_phit, rx_phit, wd;
  logic [CNT_W-1:0] outstanding_count;
  logic [TAG_W-1:0] tags [256];
  logic [DATA_W-1:0] expq [$];
  int error_cnt = 0, checks = 0, go_cnt = 0, ug_cnt = 0, pe_cnt = 0, de_cnt = 0, cyc = 0;

  always #2 mclk = ~mclk;

  btrw_engine uut (.mclk(mclk), .reset(reset), .ctrl_go(ctrl_go), .xfer_blocks(xfer_blocks),
    .xfer_local_addr(xfer_local_addr), .xfer_remote_addr(xfer_remote_addr),
    .xfer_dest_pe(xfer_dest_pe), .node_pe_id(node_pe_id), .pe_virt_base(pe_virt_base),
    .tag_wr_en(tag_wr_en), .tag_wr_addr(tag_wr_addr), .tag_wr_data(tag_wr_data),
    .write_reference_request(write_reference_request), .go_write_cmd(go_write_cmd),
    .go_read_cmd(go_read_cmd), .dram_req(dram_req), .dram_grant(dram_grant),
    .chan_req(chan_req), .chan_grant(chan_grant), .dram_ras_n(dram_ras_n),
    .dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n), .dram_addr(dram_addr),
    .dram_wdata(dram_wdata), .dram_rdata(dram_rdata), .tx_valid(tx_valid), .tx_phit(tx_phit),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_phit(rx_phit),
    .rx_last(rx_last), .rx_ready(rx_ready), .buffer_unload_grant(buffer_unload_grant),
    .parity_error(parity_error), .dest_error(dest_error),
    .outstanding_count(outstanding_count), .xfer_complete(xfer_complete));

  btrw_far_model far (.mclk(mclk), .reset(reset), .dram_req(dram_req),
    .dram_grant(dram_grant), .chan_req(chan_req), .chan_grant(chan_grant),
    .dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n), .dram_addr(dram_addr),
    .dram_rdata(dram_rdata), .tx_valid(tx_valid), .tx_phit(tx_phit), .tx_last(tx_last),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_phit(rx_phit), .rx_last(rx_last),
    .rx_ready(rx_ready));

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // cycle ceiling; a hang ends in the same verdict as a mismatch
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // watcher: each accepted phit is held against the oldest note
  always @(posedge mclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (expq.size() == 0) chk(tx_phit, 64'hx);
      else chk(tx_phit, expq.pop_front());
    end
    if (xfer_complete === 1'b1) done = 1'b1;
    if (go_write_cmd === 1'b1 && go_read_cmd === 1'b1) go_cnt++;
    if (buffer_unload_grant === 1'b1) ug_cnt++;
    if (parity_error === 1'b1) pe_cnt++;
    if (dest_error === 1'b1) de_cnt++;
    if (dram_cas_n === 1'b0 && dram_we_n === 1'b0) wd = dram_wdata;
  end

  // local read then one request per block; responses bring the count home
  task automatic run_xfer(input logic [PE_W-1:0] dest, input logic [CNT_W-1:0] n);
    logic [LPE_W-1:0] lg;
    logic [ADDR_W-1:0] la, ra;
    int k;
    la = 24'($urandom);
    ra = 24'($urandom);
    lg = dest[12] ? dest[11:0] + pe_virt_base : dest[11:0];
    for (int i = 0; i < n; i++) begin
      expq.push_back({48'h0, tags[lg[7:0]]});
      expq.push_back(far.hdr(4'h6, {1'b0, lg}, {1'b0, node_pe_id}, 1'b1));
      expq.push_back({^(ra + 24'(i)), 39'h0, ra + 24'(i)});
      expq.push_back(far.dat(la[11:0] + 12'(i)));
    end
    done = 1'b0;
    go_cnt = 0;
    @(negedge mclk);
    xfer_blocks = n;
    xfer_local_addr = la;
    xfer_remote_addr = ra;
    xfer_dest_pe = dest;
    ctrl_go = 1'b1;
    @(negedge mclk);
    chk(write_reference_request, 64'h1);
    k = 0;
    while (done !== 1'b1 && k < 4000) begin
      @(negedge mclk);
      k++;
    end
    chk(done, 64'h1);
    chk(outstanding_count, 64'h0);
    chk(go_cnt, n);
    chk(expq.size(), 64'h0);
    ctrl_go = 1'b0;
    repeat (2) @(negedge mclk);
    $display("transfer of %0d blocks to %h done", n, dest);
  endtask

  // a packet from a remote node: written and answered, or dropped with a flag
  task automatic inbound(input logic [PE_W-1:0] dst, input logic [63:0] flip, input logic good,
      input int xpe, input int xde);
    logic [63:0] p [4];
    logic [ADDR_W-1:0] ra;
    logic [63:0] d;
    int k;
    ra = 24'($urandom);
    d = {$urandom, $urandom};
    p = '{64'h0123_4567_89ab_cdef, far.hdr(4'h6, dst, 13'h0055, 1'b1) ^ flip,
      {^ra, 39'h0, ra}, d};
    ug_cnt = 0;
    pe_cnt = 0;
    de_cnt = 0;
    wd = ~d;
    if (good) begin
      expq.push_back({48'h0, tags[8'h55]});
      expq.push_back(far.hdr(4'h0, 13'h0055, 13'h0, 1'b0));
    end
    far.send(p, 4);
    k = 0;
    while ((good ? expq.size() != 0 : pe_cnt + de_cnt == 0) && k < 200) begin
      @(negedge mclk);
      k++;
    end
    repeat (20) @(negedge mclk);
    chk(ug_cnt, 64'h1);
    chk(pe_cnt, xpe);
    chk(de_cnt, xde);
    chk(wd, good ? d : ~d);
    chk(expq.size(), 64'h0);
    $display("inbound packet with flip %h to %h done", flip, dst);
  endtask

  initial begin
    void'($urandom(71378));
    node_pe_id = 12'($urandom);
    pe_virt_base = 12'($urandom);
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    chk({rx_ready, tx_valid, dram_ras_n, dram_cas_n, dram_we_n, xfer_complete}, 6'h2e);
    for (int i = 0; i < 256; i++) begin
      @(negedge mclk);
      tags[i] = 16'($urandom);
      tag_wr_en = 1'b1;
      tag_wr_addr = 8'(i);
      tag_wr_data = tags[i];
    end
    @(negedge mclk);
    tag_wr_en = 1'b0;
    run_xfer({1'b0, 12'($urandom)}, 17'h00003);
    run_xfer({1'b1, 12'($urandom)}, 17'($urandom_range(4, 1)));
    run_xfer({1'b0, node_pe_id}, 17'h00001);
    inbound({1'b0, node_pe_id}, 64'h0, 1'b1, 0, 0);
    inbound({1'b0, node_pe_id}, 64'h4, 1'b0, 1, 0);
    inbound({1'b0, node_pe_id}, 64'h1, 1'b0, 1, 0);
    inbound({1'b0, node_pe_id ^ 12'h001}, 64'h0, 1'b0, 0, 1);
    // stray response with a broken command parity: flagged, count left alone
    pe_cnt = 0;
    far.send('{64'h0, far.hdr(4'h0, {1'b0, node_pe_id}, 13'h0, 1'b0) ^ 64'h4, '0, '0}, 2);
    repeat (10) @(negedge mclk);
    chk(pe_cnt, 64'h1);
    chk(outstanding_count, 64'h0);
    $display("stray response with bad command parity dropped");
    give_verdict();
  end
endmodule
`default_nettype wire
